// *** include/sahl_defs.vh ***
// Constants and the operation overview of the serial converter link.
// Overview of operation
// - Select falling edge enables serial output, input and clock for a transfer.
// - Select rising edge disables serial output, input and clock, ending transfer.
// - Result output driven only while select low, released while select high.
// - End-of-conversion goes high once a result is ready to shift out.
// - Multiplexer offers 14 sources: 11 external inputs, three self-test levels.
// - Sample-and-hold of the chosen input happens automatically, without a command.
// - Each conversion gives a 12-bit successive-approximation result, returned serially.
`ifndef SAHL_DEFS_VH
`define SAHL_DEFS_VH
`define SAHL_RES_W      12
`define SAHL_CMD_W      4
`define SAHL_CH_W       4
`define SAHL_CMD_BITS   4'h4
`define SAHL_FRAME_BITS 4'hc
`define SAHL_NUM_EXT    4'ha
`define SAHL_NUM_SRC    4'he
`define SAHL_ST_REFHALF 4'hb
`define SAHL_ST_REFLO   4'hc
`define SAHL_ST_REFHI   4'hd
`define SAHL_VAL_HALF   12'h800
`define SAHL_VAL_LO     12'h000
`define SAHL_VAL_HI     12'hfff
`define SAHL_CNT_W      4
`define SAHL_CLK_MHZ    100
`define SAHL_SAMPLE_NS  1000
`define SAHL_SAMPLE_CYC ((`SAHL_SAMPLE_NS * `SAHL_CLK_MHZ + 999) / 1000)
`endif

// *** src/sahl_sar.v ***
// Successive-approximation engine: one result bit per clock against a held sample.
`timescale 1ns/1ps
`include "sahl_defs.vh"
module sahl_sar (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  // Control
  input  wire                    start,
  input  wire [`SAHL_RES_W-1:0]  sample,
  // Result
  output reg                     done_q,
  output reg  [`SAHL_RES_W-1:0]  result_q
);
  reg [`SAHL_RES_W-1:0] trial_q;
  reg [`SAHL_RES_W-1:0] held_q;
  reg                   busy_q;

  // A trial bit is kept when the comparator says the sample is at or above it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trial_q  <= 12'h000;
      held_q   <= 12'h000;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      result_q <= 12'h000;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        held_q   <= sample;
        trial_q  <= 12'h800;
        result_q <= 12'h000;
        busy_q   <= 1'b1;
      end else if (busy_q) begin
        if (held_q >= (result_q | trial_q)) begin
          result_q <= result_q | trial_q;
        end
        trial_q <= trial_q >> 1;
        if (trial_q == 12'h001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule // sahl_sar

// *** src/sahl_top.v ***
// Device-side serial link of the 12-bit multiplexed converter.
`timescale 1ns/1ps
`include "sahl_defs.vh"
module sahl_top (
  // System
  input  wire                    CLK_SYS,
  input  wire                    RST_N,
  // Serial link pins
  input  wire                    CS_N,
  input  wire                    SCLK,
  input  wire                    SDI,
  output reg                     SDO,
  output wire                    SDO_OE,
  // Conversion status
  output reg                     EOC,
  // Analog sources modelled as digital codes
  input  wire [11*`SAHL_RES_W-1:0] AIN
);
  reg       rst_m_q;
  reg       rst_q;
  wire      rst_n = rst_q;

  // Reset is taken at once but let go only on a clock edge, through two stages,
  // so that no register leaves reset a cycle ahead of its neighbours.
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_q <= 1'b0;
      rst_q   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_q   <= rst_m_q;
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  // The third stage only remembers the last settled level for edge finding.
  // Pins reach logic two clocks late, so a link clock half period must span
  // at least two system clocks or its edges are missed.
  reg [2:0] cs_s_q;
  reg [2:0] ck_s_q;
  reg [1:0] di_s_q;

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_q <= 3'h7;
      ck_s_q <= 3'h0;
      di_s_q <= 2'h0;
    end else begin
      cs_s_q <= {cs_s_q[1:0], CS_N};
      ck_s_q <= {ck_s_q[1:0], SCLK};
      di_s_q <= {di_s_q[0], SDI};
    end
  end

  wire cs_low  = ~cs_s_q[1];
  wire cs_fall = cs_s_q[2] & ~cs_s_q[1];
  wire cs_rise = ~cs_s_q[2] & cs_s_q[1];
  wire ck_rise = ~ck_s_q[2] & ck_s_q[1];
  wire ck_fall = ck_s_q[2] & ~ck_s_q[1];
  wire din     = di_s_q[1];

  // The analog codes arrive from outside this clock's domain as a whole word.
  // They are held still through the sampling window, so two plain stages are enough;
  // a code that moved during sampling would need a handshake instead.
  reg [11*`SAHL_RES_W-1:0] ain_m_q;
  reg [11*`SAHL_RES_W-1:0] ain_q;

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ain_m_q <= {(11*`SAHL_RES_W){1'b0}};
      ain_q   <= {(11*`SAHL_RES_W){1'b0}};
    end else begin
      ain_m_q <= AIN;
      ain_q   <= ain_m_q;
    end
  end

  // Frame and shift state.
  reg                    active_q;
  reg [`SAHL_CNT_W-1:0]  bitcnt_q;
  reg [`SAHL_CMD_W-1:0]  cmd_q;
  reg [`SAHL_RES_W-1:0]  shout_q;
  reg [`SAHL_RES_W-1:0]  last_q;
  reg [`SAHL_CH_W-1:0]   chan_q;
  reg                    start_conv_q;
  reg [7:0]              smp_cnt_q;
  reg [1:0]              cv_state_q;
  reg [`SAHL_RES_W-1:0]  sample_q;

  wire                   sar_done;
  wire [`SAHL_RES_W-1:0] sar_result;

  // A frame that carried a whole channel field starts a conversion as it closes.
  wire                   frame_close = cs_rise & active_q & (bitcnt_q >= `SAHL_CMD_BITS);

  // Conversion sequencer states.
  localparam CV_IDLE   = 2'b00;
  localparam CV_SAMPLE = 2'b01;
  localparam CV_CONV   = 2'b10;

  // A select glitch during reset cannot leave the output enabled.
  assign SDO_OE = cs_low & active_q;

  // The result moves on a falling link clock so that each bit stands across the
  // host's next rise; a fall before the first rise shifts nothing.
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      active_q     <= 1'b0;
      bitcnt_q     <= 4'h0;
      cmd_q        <= 4'h0;
      shout_q      <= 12'h000;
      SDO          <= 1'b0;
    end else begin
      if (cs_fall) begin
        active_q <= 1'b1;
        bitcnt_q <= 4'h0;
        shout_q  <= last_q;
        SDO      <= last_q[`SAHL_RES_W-1];
      end else if (cs_rise) begin
        active_q <= 1'b0;
      end else if (active_q && cs_low) begin
        // Rises past the last result bit are ignored so the count cannot wrap.
        if (ck_rise && bitcnt_q != `SAHL_FRAME_BITS) begin
          // Command bits land MSB first; bits past the command field are ignored.
          if (bitcnt_q < `SAHL_CMD_BITS) begin
            cmd_q <= {cmd_q[`SAHL_CMD_W-2:0], din};
          end
          bitcnt_q <= bitcnt_q + 4'h1;
        end
        if (ck_fall && bitcnt_q != 4'h0) begin
          shout_q <= {shout_q[`SAHL_RES_W-2:0], 1'b0};
          SDO     <= shout_q[`SAHL_RES_W-2];
        end
      end
    end
  end

  // The conversion starts when the frame closes, after automatic sampling.
  // A frame that closes while a conversion is under way is not taken: the host
  // must wait for the end-of-conversion flag, and restarting would lose a result.
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cv_state_q   <= CV_IDLE;
      chan_q       <= 4'h0;
      smp_cnt_q    <= 8'h00;
      start_conv_q <= 1'b0;
      sample_q     <= 12'h000;
      last_q       <= 12'h000;
      // Nothing is pending out of reset, and the first frame returns zero.
      EOC          <= 1'b1;
    end else begin
      start_conv_q <= 1'b0;
      case (cv_state_q)
        CV_IDLE: begin
          if (frame_close) begin
            chan_q     <= cmd_q;
            smp_cnt_q  <= 8'h00;
            EOC        <= 1'b0;
            cv_state_q <= CV_SAMPLE;
          end
        end
        CV_SAMPLE: begin
          // The held value is taken from the settled codes at the window's end.
          if ({24'h000000, smp_cnt_q} == (`SAHL_SAMPLE_CYC - 1)) begin
            start_conv_q <= 1'b1;
            sample_q     <= src_code(chan_q, ain_q);
            cv_state_q   <= CV_CONV;
          end else begin
            smp_cnt_q <= smp_cnt_q + 8'h01;
          end
        end
        CV_CONV: begin
          if (sar_done) begin
            last_q     <= sar_result;
            EOC        <= 1'b1;
            cv_state_q <= CV_IDLE;
          end
        end
        default: begin
          cv_state_q <= CV_IDLE;
        end
      endcase
    end
  end

  // Channels past the self-test codes read as the lowest level.
  function [`SAHL_RES_W-1:0] src_code;
    input [`SAHL_CH_W-1:0]     ch;
    input [11*`SAHL_RES_W-1:0] ain;
    begin
      case (ch)
        `SAHL_ST_REFHALF: begin
          src_code = `SAHL_VAL_HALF;
        end
        `SAHL_ST_REFLO: begin
          src_code = `SAHL_VAL_LO;
        end
        `SAHL_ST_REFHI: begin
          src_code = `SAHL_VAL_HI;
        end
        default: begin
          // External input codes, and codes that are neither external inputs nor self-test levels.
          if (ch <= `SAHL_NUM_EXT) begin
            src_code = ain[ch*`SAHL_RES_W +: `SAHL_RES_W];
          end else begin
            src_code = `SAHL_VAL_LO;
          end
        end
      endcase
    end
  endfunction

  // The engine loads for one clock, then decides one bit per clock, so a result follows its start strobe
  // by thirteen clocks and the busy span is short beside the sampling span.
  sahl_sar u_sar (
    .clk      (CLK_SYS),
    .rst_n    (rst_n),
    .start    (start_conv_q),
    .sample   (sample_q),
    .done_q   (sar_done),
    .result_q (sar_result)
  );
endmodule // sahl_top

// *** sim/sahl_top_chk.sv ***
// Port-level checks on the converter link.
`timescale 1ns/1ps
module sahl_top_chk (
  // Watched ports
  input wire CLK_SYS,
  input wire RST_N,
  input wire CS_N,
  input wire SCLK,
  input wire SDO,
  input wire SDO_OE,
  input wire EOC
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  AST_OE_OFF: assert property (CS_N [*5] |-> !SDO_OE)
    else $error("output driven while deselected");
  AST_OE_ON: assert property (!CS_N [*6] |-> SDO_OE)
    else $error("output not enabled in frame");
  AST_OE_DROP: assert property ($rose(CS_N) |-> ##[1:5] !SDO_OE)
    else $error("output not released at frame end");
  AST_EOC_FRAME: assert property ($rose(SDO_OE) |-> EOC [*2])
    else $error("frame started without a ready result");
  AST_EOC_TIME: assert property ($fell(EOC) |-> ##[100:140] EOC)
    else $error("conversion did not finish in time");
  AST_EOC_SAMPLE: assert property ($rose(EOC) |-> !$past(EOC, 100))
    else $error("sampling period cut short");
  AST_SDO_CHG: assert property (SDO_OE && $past(SDO_OE) && $changed(SDO) |-> !SCLK)
    else $error("result bit moved while link clock high");
  AST_SDO_HOLD: assert property (SDO_OE && $past(SCLK, 3) && SCLK |-> $stable(SDO))
    else $error("result bit unstable in high phase");
  cover property ($fell(EOC));
  cover property ($rose(EOC));
  cover property ($fell(SDO_OE));
endmodule // sahl_top_chk
bind sahl_top sahl_top_chk u_sahl_top_chk (.CLK_SYS, .RST_N, .CS_N, .SCLK, .SDO, .SDO_OE, .EOC);

// *** sim/sahl_host.sv ***
// Host model that clocks frames through the converter link.
`timescale 1ns/1ps
module sahl_host (
  // Pacing clock
  input wire   clk,
  // Link
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire   sdo,
  input wire   sdo_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Four system cycles per half period gives the 80 ns link clock.
  task frame(input logic [3:0] ch, input int n, output logic [11:0] rx);
    int i;
    begin
      rx = 12'hxxx;
      @(negedge clk) cs_n = 1'b0;
      repeat (8) @(negedge clk);
      for (i = 0; i < n; i++) begin
        sdi = (i < 4) ? ch[3 - i] : ~sdi;
        repeat (4) @(negedge clk);
        // Read late in the low phase, once the device has seen the last fall.
        rx = {rx[10:0], sdo_oe ? sdo : 1'bx};
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      sdi = ~sdi;
    end
  endtask
endmodule // sahl_host

// *** sim/test_sahl_top.sv ***
// Self-checking bench for the converter link.
`timescale 1ns/1ps
module test_sahl_top;
  logic         clk_sys = 1'b0;
  logic         rst_n;
  logic         cs_n, sclk, sdi, sdo, sdo_oe, eoc;
  logic [131:0] ain;
  logic [11:0]  rx, want;
  int           bad_count = 0, checked = 0, i, n;
  logic [15:0]  rows [0:14] = '{16'he000, 16'h005a, 16'h115a, 16'h225a, 16'h335a,
    16'h445a, 16'h555a, 16'h665a, 16'h775a, 16'h885a, 16'h995a, 16'haa5a, 16'hb800,
    16'hc000, 16'hdfff};
  sahl_top u_sahl_top (.CLK_SYS(clk_sys), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk),
    .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .EOC(eoc), .AIN(ain));
  sahl_host u_sahl_host (.clk(clk_sys), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task check(input logic [11:0] got, input logic [11:0] exp_v);
    begin
      checked++;
      if (got !== exp_v) begin
        bad_count++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp_v);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task frame_end;
    begin
      repeat (6) @(negedge clk_sys);
      check(sdo_oe, 0);
      check(eoc, 0);
      n = 0;
      while (eoc !== 1'b1 && n < 300) begin
        @(negedge clk_sys);
        n++;
      end
      check(n >= 95 && n < 300, 1);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    for (i = 0; i < 11; i++) ain[12*i +: 12] = {i[3:0], 8'h5a};
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    check(sdo_oe, 0);
    check(eoc, 1);
    want = 12'h000;
    for (i = 0; i < 15; i++) begin
      u_sahl_host.frame(rows[i][15:12], 12, rx);
      check(rx, want);
      want = rows[i][11:0];
      frame_end;
    end
    // Too few bits clocked starts no conversion, so the old result stays.
    u_sahl_host.frame(4'h0, 3, rx);
    check(rx[2:0], 3'h7);
    repeat (6) @(negedge clk_sys);
    check(eoc, 1);
    u_sahl_host.frame(4'h0, 12, rx);
    check(rx, 12'hfff);
    frame_end;
    rst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    check(sdo_oe, 0);
    check(eoc, 1);
    u_sahl_host.frame(4'h1, 12, rx);
    check(rx, 12'h000);
    frame_end;
    report_and_stop;
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
endmodule // test_sahl_top
